//--- hdl/dmrb_defs.svh
// constants of the mode register and burst sequencer
// assumes one 40 MHz clock shared by controller and memory ends
`ifndef DMRB_DEFS_SVH
`define DMRB_DEFS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define DMRB_AW         13
`define DMRB_DW         8
`define DMRB_COLW       11
`define DMRB_MEMAW      6
`define DMRB_MEMCOLW    4

// ----------------------------------------
// op-code fields
// ----------------------------------------
`define DMRB_BL_LSB     0
`define DMRB_BL_MSB     2
`define DMRB_BT_BIT     3
`define DMRB_CL_LSB     4
`define DMRB_CL_MSB     6
`define DMRB_OM_LSB     7
`define DMRB_OM_MSB     12
`define DMRB_DLL_BIT    8
`define DMRB_LOWF_MSB   6
`define DMRB_COLHI_BIT  11
`define DMRB_COLLO_MSB  9

// ----------------------------------------
// field codes
// ----------------------------------------
`define DMRB_BL2        3'h1
`define DMRB_BL4        3'h2
`define DMRB_BL8        3'h3
`define DMRB_MASK2      3'h1
`define DMRB_MASK4      3'h3
`define DMRB_MASK8      3'h7
`define DMRB_CL2        3'h2
`define DMRB_CL25       3'h6
`define DMRB_CL3        3'h3
`define DMRB_OM_NORMAL  6'h00
`define DMRB_OM_DLL     6'h02
`define DMRB_BANK_MODE  2'h0
`define DMRB_MODE_RST   13'h0021
`define DMRB_BT_SEQ     1'h0

// ----------------------------------------
// timing
// ----------------------------------------
`define DMRB_CLK_NS     25
`define DMRB_MRD_NS     15
`define DMRB_MRD_CYC    ((`DMRB_MRD_NS + `DMRB_CLK_NS - 1) / `DMRB_CLK_NS)
`define DMRB_RD_TAIL    4'h4
`define DMRB_WR_TAIL    4'h1

`endif

//--- hdl/dmrb_device.sv
// memory end: mode register, burst ordering, read latency, small array
// assumes commands arrive synchronous to clk from the controller end
//
// Function
// R1 - mode write needs both bank selects low
// R2 - register holds value; dll bit self-clears
// R3 - mode write leaves array contents intact
// R4 - controller writes mode only when idle
// R5 - fields: length, type, latency, operating mode
// R6 - burst lengths 2, 4, 8, both types
// R7 - controller never programs reserved lengths
// R8 - burst wraps inside aligned block
// R9 - block bits reach column bit 11
// R10 - length applies to reads and writes
// R11 - type bit picks sequential or interleaved
// R12 - sequential adds, interleaved xors index
// R13 - first read data at edge n+m
// R14 - latencies 2, 2.5 and 3 accepted
// R15 - controller picks latency fitting its clock
// R16 - normal mode: bits 7..12 zero
// R17 - dll reset: bit 8 only set
// R18 - dll reset followed by normal write
// R19 - controller writes no reserved mode bits
// R20 - inputs sampled each rising clock edge
// R21 - address bits 0..12 carry op-code
// R22 - customary field codes
// R23 - dll bit reads zero next clock
`timescale 1ns/1ps
`include "dmrb_defs.svh"

module dmrb_device (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // link
  dmrb_if.device                      link,
  // mode and burst observation
  output logic [`DMRB_BL_MSB:0]       burstLenCode,
  output logic                        burstOrder,
  output logic [2:0]                  readLatencySetting,
  output logic [5:0]                  opMode,
  output logic                        dllResetBit,
  output logic                        burstBusy
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [`DMRB_AW-1:0]      modeReg;
  logic                     dllReg;
  logic                     burstActive;
  logic                     burstWrite;
  logic [1:0]               burstBank;
  logic [`DMRB_COLW-1:0]    burstCol;
  logic [2:0]               burstIdx;
  logic                     pipe1Valid;
  logic [`DMRB_DW-1:0]      pipe1Data;
  logic                     pipe2Valid;
  logic [`DMRB_DW-1:0]      pipe2Data;
  logic                     outValid;
  logic [`DMRB_DW-1:0]      outData;
  logic                     outHalf;
  logic [`DMRB_DW-1:0]      mem [0:(1<<`DMRB_MEMAW)-1];

  logic [`DMRB_AW-1:0]      next_modeReg;
  logic                     next_dllReg;
  logic                     next_burstActive;
  logic                     next_burstWrite;
  logic [1:0]               next_burstBank;
  logic [`DMRB_COLW-1:0]    next_burstCol;
  logic [2:0]               next_burstIdx;
  logic                     next_pipe1Valid;
  logic                     next_pipe2Valid;
  logic                     next_outValid;
  logic [`DMRB_DW-1:0]      next_outData;
  logic                     next_outHalf;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  dmrb_pkg::dmrb_cmd_t      cmd;
  logic [2:0]               blCode;
  logic [2:0]               clCode;
  logic [2:0]               blMask;
  logic [2:0]               offset;
  logic [`DMRB_COLW-1:0]    accCol;
  logic [`DMRB_MEMAW-1:0]   accAddr;
  logic [`DMRB_COLW-1:0]    cmdCol;
  logic [5:0]               newMode;
  logic                     slowLatency;

  always_comb begin
    cmd = dmrb_pkg::dmrb_cmd_t'({link.csN, link.rasN, link.casN, link.weN}); // [R20]
    blCode = modeReg[`DMRB_BL_MSB:`DMRB_BL_LSB];                              // [R5]
    clCode = modeReg[`DMRB_CL_MSB:`DMRB_CL_LSB];                              // [R5]
    newMode = link.addr[`DMRB_OM_MSB:`DMRB_OM_LSB];                           // [R21]
    // reserved length codes fall back to the shortest burst
    unique case (blCode)                                                      // [R22] [R6]
      `DMRB_BL4: blMask = `DMRB_MASK4;
      `DMRB_BL8: blMask = `DMRB_MASK8;
      default:   blMask = `DMRB_MASK2;
    endcase
    // 2.5 runs on the 3-cycle pipe with the half flag set
    slowLatency = (clCode == `DMRB_CL3) || (clCode == `DMRB_CL25);            // [R14] [R22]
    if (modeReg[`DMRB_BT_BIT] == `DMRB_BT_SEQ) begin                          // [R11]
      offset = (burstCol[2:0] + burstIdx) & blMask;                           // [R12]
    end else begin
      offset = (burstCol[2:0] ^ burstIdx) & blMask;                           // [R12]
    end
    accCol = (burstCol & ~{8'h00, blMask}) | {8'h00, offset};                 // [R8] [R9]
    accAddr = {burstBank, accCol[`DMRB_MEMCOLW-1:0]};
    cmdCol = {link.addr[`DMRB_COLHI_BIT], link.addr[`DMRB_COLLO_MSB:0]};      // [R9]
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_modeReg = modeReg;
    next_dllReg = 1'b0;                                                       // [R23] [R2]
    next_burstActive = burstActive;
    next_burstWrite = burstWrite;
    next_burstBank = burstBank;
    next_burstCol = burstCol;
    next_burstIdx = burstIdx;
    next_pipe1Valid = 1'b0;
    next_pipe2Valid = pipe1Valid && slowLatency;
    next_outValid = 1'b0;
    next_outData = outData;
    next_outHalf = 1'b0;

    // burst stepping; one access per clock
    if (burstActive) begin
      next_pipe1Valid = !burstWrite;                                          // [R10]
      if (burstIdx == blMask) begin
        next_burstActive = 1'b0;
      end else begin
        next_burstIdx = burstIdx + 3'h1;
      end
    end

    // command taken at this edge; a new burst truncates the old one
    unique case (cmd)
      dmrb_pkg::CMD_LMR: begin
        // mode write touches no array location
        if (link.bankSel == `DMRB_BANK_MODE) begin                            // [R1] [R3]
          if (newMode == `DMRB_OM_NORMAL) begin                               // [R16]
            next_modeReg = link.addr;                                         // [R21] [R2]
          end else if (newMode == `DMRB_OM_DLL) begin                         // [R17]
            next_modeReg = {`DMRB_OM_NORMAL, link.addr[`DMRB_LOWF_MSB:0]};
            next_dllReg = 1'b1;                                               // [R2]
          end else begin
            // test and reserved modes keep only the low fields
            next_modeReg = {modeReg[`DMRB_OM_MSB:`DMRB_OM_LSB],
                            link.addr[`DMRB_LOWF_MSB:0]};
          end
        end
      end
      dmrb_pkg::CMD_READ, dmrb_pkg::CMD_WRITE: begin
        next_burstActive = 1'b1;
        next_burstWrite = (cmd == dmrb_pkg::CMD_WRITE);
        next_burstBank = link.bankSel;
        next_burstCol = cmdCol;
        next_burstIdx = 3'h0;
      end
      default: begin
      end
    endcase

    // read latency: output register loads at edge n+m
    if (slowLatency) begin                                                    // [R13]
      if (pipe2Valid) begin
        next_outValid = 1'b1;
        next_outData = pipe2Data;
        next_outHalf = (clCode == `DMRB_CL25);
      end
    end else if (pipe1Valid) begin                                           // [R13]
      next_outValid = 1'b1;
      next_outData = pipe1Data;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modeReg <= `DMRB_MODE_RST;
      dllReg <= 1'b0;
      burstActive <= 1'b0;
      burstWrite <= 1'b0;
      burstBank <= 2'h0;
      burstCol <= 11'h000;
      burstIdx <= 3'h0;
      pipe1Valid <= 1'b0;
      pipe2Valid <= 1'b0;
      outValid <= 1'b0;
      outData <= 8'h00;
      outHalf <= 1'b0;
    end else begin
      modeReg <= next_modeReg;
      dllReg <= next_dllReg;
      burstActive <= next_burstActive;
      burstWrite <= next_burstWrite;
      burstBank <= next_burstBank;
      burstCol <= next_burstCol;
      burstIdx <= next_burstIdx;
      pipe1Valid <= next_pipe1Valid;
      pipe2Valid <= next_pipe2Valid;
      outValid <= next_outValid;
      outData <= next_outData;
      outHalf <= next_outHalf;
    end
  end

  // ----------------------------------------
  // array and read pipe data (no reset: contents are data)
  // ----------------------------------------
  always_ff @(posedge clk) begin
    // word k lands at edge n+1+k, while the host still shows it
    if (burstActive && burstWrite) begin
      mem[accAddr] <= link.wrData;                                            // [R10]
    end
    pipe1Data <= mem[accAddr];
    pipe2Data <= pipe1Data;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign link.rdValid = outValid;
  assign link.rdData = outData;
  assign link.rdHalf = outHalf;
  assign burstLenCode = modeReg[`DMRB_BL_MSB:`DMRB_BL_LSB];
  assign burstOrder = modeReg[`DMRB_BT_BIT];
  assign readLatencySetting = modeReg[`DMRB_CL_MSB:`DMRB_CL_LSB];
  assign opMode = modeReg[`DMRB_OM_MSB:`DMRB_OM_LSB];
  assign dllResetBit = dllReg;
  assign burstBusy = burstActive;

endmodule

//--- hdl/dmrb_host.sv
// controller end: queues user requests and issues mode, read, write
// assumes the memory end shares clk; read data arrives at n+m
`timescale 1ns/1ps
`include "dmrb_defs.svh"

module dmrb_host (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // link
  dmrb_if.host                        link,
  // user requests
  input  wire logic                   reqValid,
  output logic                        reqReady,
  input  wire logic [1:0]             reqOp,
  input  wire logic [1:0]             reqBank,
  input  wire logic [`DMRB_AW-1:0]    reqAddr,
  input  wire logic [`DMRB_DW-1:0]    reqData,
  // user responses
  output logic                        rspValid,
  output logic [`DMRB_DW-1:0]         rspData,
  output logic                        rspHalf,
  output logic                        reqRefused,
  output logic                        busy
);

  localparam int EW = 2 + 2 + `DMRB_AW + `DMRB_DW;

  // ----------------------------------------
  // two-entry request buffer
  // ----------------------------------------
  logic [EW-1:0]  fifo [0:1];
  logic           wrPtr;
  logic           rdPtr;
  logic [1:0]     count;
  logic           push;
  logic           pop;
  logic [EW-1:0]  head;

  // refusing while full is what stalls the user side
  assign reqReady = (count != 2'h2);
  assign push = reqValid && reqReady;
  assign head = fifo[rdPtr];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
    end else begin
      wrPtr <= wrPtr ^ push;
      rdPtr <= rdPtr ^ pop;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      fifo[wrPtr] <= {reqOp, reqBank, reqAddr, reqData};
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  dmrb_pkg::dmrb_hstate_t  state;
  dmrb_pkg::dmrb_hstate_t  next_state;
  logic [3:0]              cmdBits;
  logic [3:0]              next_cmdBits;
  logic [1:0]              bankOut;
  logic [1:0]              next_bankOut;
  logic [`DMRB_AW-1:0]     addrOut;
  logic [`DMRB_AW-1:0]     next_addrOut;
  logic [`DMRB_DW-1:0]     wdOut;
  logic [`DMRB_DW-1:0]     next_wdOut;
  logic [2:0]              hostMask;
  logic [2:0]              next_hostMask;
  logic [3:0]              cnt;
  logic [3:0]              next_cnt;
  logic [1:0]              curOp;
  logic [1:0]              next_curOp;
  logic                    pendNormal;
  logic                    next_pendNormal;
  logic                    refused;
  logic                    next_refused;
  logic [1:0]              hOp;
  logic [`DMRB_AW-1:0]     hAddr;
  logic [2:0]              hBl;
  logic [2:0]              hCl;
  logic [5:0]              hOm;
  logic                    legal;
  logic [2:0]              newMask;

  always_comb begin
    hOp = head[EW-1:EW-2];
    hAddr = head[`DMRB_AW+`DMRB_DW-1:`DMRB_DW];
    hBl = hAddr[`DMRB_BL_MSB:`DMRB_BL_LSB];
    hCl = hAddr[`DMRB_CL_MSB:`DMRB_CL_LSB];
    hOm = hAddr[`DMRB_OM_MSB:`DMRB_OM_LSB];
    // any listed latency suits a 40 MHz clock
    legal = ((hBl == `DMRB_BL2) || (hBl == `DMRB_BL4) || (hBl == `DMRB_BL8))  // [R7]
         && ((hCl == `DMRB_CL2) || (hCl == `DMRB_CL25) || (hCl == `DMRB_CL3)) // [R15]
         && ((hOm == `DMRB_OM_NORMAL) || (hOm == `DMRB_OM_DLL));               // [R19]
    unique case (hBl)
      `DMRB_BL4: newMask = `DMRB_MASK4;
      `DMRB_BL8: newMask = `DMRB_MASK8;
      default:   newMask = `DMRB_MASK2;
    endcase
  end

  always_comb begin
    next_state = state;
    next_cmdBits = dmrb_pkg::CMD_NOP;
    next_bankOut = bankOut;
    next_addrOut = addrOut;
    next_wdOut = wdOut;
    next_hostMask = hostMask;
    next_cnt = cnt;
    next_curOp = curOp;
    next_pendNormal = pendNormal;
    next_refused = 1'b0;
    pop = 1'b0;
    unique case (state)
      dmrb_pkg::H_IDLE: begin
        if (pendNormal) begin
          next_cmdBits = dmrb_pkg::CMD_LMR;                                   // [R18]
          next_bankOut = `DMRB_BANK_MODE;
          next_addrOut = {`DMRB_OM_NORMAL, addrOut[`DMRB_LOWF_MSB:0]};         // [R16]
          next_curOp = dmrb_pkg::OP_MODE;
          next_pendNormal = 1'b0;
          next_state = dmrb_pkg::H_CMD;
        end else if (count != 2'h0) begin
          pop = 1'b1;
          next_curOp = hOp;
          next_addrOut = hAddr;
          next_bankOut = head[EW-3:EW-4];
          next_wdOut = head[`DMRB_DW-1:0];
          if (hOp == dmrb_pkg::OP_MODE) begin
            if (legal) begin
              next_cmdBits = dmrb_pkg::CMD_LMR;
              next_bankOut = `DMRB_BANK_MODE;                                 // [R1]
              next_hostMask = newMask;
              next_pendNormal = (hOm == `DMRB_OM_DLL);                        // [R17]
              next_state = dmrb_pkg::H_CMD;
            end else begin
              next_refused = 1'b1;
            end
          end else if (hOp == dmrb_pkg::OP_WRITE) begin
            next_cmdBits = dmrb_pkg::CMD_WRITE;
            next_state = dmrb_pkg::H_CMD;
          end else begin
            next_cmdBits = dmrb_pkg::CMD_READ;
            next_state = dmrb_pkg::H_CMD;
          end
        end
      end
      dmrb_pkg::H_CMD: begin
        next_cnt = 4'h0;
        if (curOp == dmrb_pkg::OP_WRITE) begin
          next_state = dmrb_pkg::H_WDATA;
        end else if (curOp == dmrb_pkg::OP_MODE) begin
          next_cnt = 4'(`DMRB_MRD_CYC);                                       // [R4]
          next_state = dmrb_pkg::H_WAIT;
        end else begin
          // drain the burst before the next command may be a mode write
          next_cnt = {1'b0, hostMask} + `DMRB_RD_TAIL;                        // [R4]
          next_state = dmrb_pkg::H_WAIT;
        end
      end
      dmrb_pkg::H_WDATA: begin
        next_wdOut = wdOut + 8'h01;                                           // [R10]
        next_cnt = cnt + 4'h1;
        if (cnt[2:0] == hostMask) begin
          next_cnt = `DMRB_WR_TAIL;
          next_state = dmrb_pkg::H_WAIT;
        end
      end
      dmrb_pkg::H_WAIT: begin
        next_cnt = cnt - 4'h1;
        if (cnt <= 4'h1) begin
          next_state = dmrb_pkg::H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= dmrb_pkg::H_IDLE;
      cmdBits <= dmrb_pkg::CMD_NOP;
      bankOut <= 2'h0;
      addrOut <= 13'h0000;
      wdOut <= 8'h00;
      hostMask <= `DMRB_MASK2;
      cnt <= 4'h0;
      curOp <= 2'h0;
      pendNormal <= 1'b0;
      refused <= 1'b0;
      rspValid <= 1'b0;
      rspData <= 8'h00;
      rspHalf <= 1'b0;
    end else begin
      state <= next_state;
      cmdBits <= next_cmdBits;
      bankOut <= next_bankOut;
      addrOut <= next_addrOut;
      wdOut <= next_wdOut;
      hostMask <= next_hostMask;
      cnt <= next_cnt;
      curOp <= next_curOp;
      pendNormal <= next_pendNormal;
      refused <= next_refused;
      rspValid <= link.rdValid;
      rspData <= link.rdData;
      rspHalf <= link.rdHalf;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign {link.csN, link.rasN, link.casN, link.weN} = cmdBits;
  assign link.bankSel = bankOut;
  assign link.addr = addrOut;
  assign link.wrData = wdOut;
  assign reqRefused = refused;
  assign busy = (state != dmrb_pkg::H_IDLE) || pendNormal;

endmodule

//--- hdl/dmrb_if.sv
// link between the controller end and the memory end
// assumes both ends share clk; the bench instantiates and joins them
`timescale 1ns/1ps
`include "dmrb_defs.svh"

interface dmrb_if;
  // command and address
  logic                  csN;
  logic                  rasN;
  logic                  casN;
  logic                  weN;
  logic [1:0]            bankSel;
  logic [`DMRB_AW-1:0]   addr;
  // data
  logic [`DMRB_DW-1:0]   wrData;
  logic [`DMRB_DW-1:0]   rdData;
  logic                  rdValid;
  logic                  rdHalf;

  modport device (
    input  csN, rasN, casN, weN, bankSel, addr, wrData,
    output rdData, rdValid, rdHalf
  );
  modport host (
    output csN, rasN, casN, weN, bankSel, addr, wrData,
    input  rdData, rdValid, rdHalf
  );
endinterface

//--- hdl/dmrb_pkg.sv
// types shared by the memory end and the controller end
// assumes dmrb_defs.svh is on the include path
package dmrb_pkg;

  // active-low {cs, ras, cas, we}
  typedef enum logic [3:0] {
    CMD_LMR   = 4'h0,
    CMD_WRITE = 4'h4,
    CMD_READ  = 4'h5,
    CMD_NOP   = 4'h7
  } dmrb_cmd_t;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_MODE  = 2'h2
  } dmrb_op_t;

  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_CMD   = 2'h1,
    H_WDATA = 2'h2,
    H_WAIT  = 2'h3
  } dmrb_hstate_t;

endpackage

//--- tb/dmrb_properties.sv
// link assertions for the controller and memory ends
// assumes one clock; tb instantiates it beside the interface
`timescale 1ns/1ps
`include "dmrb_defs.svh"

module dmrb_properties (
  // clock and reset
  input wire logic                clk,
  input wire logic                reset,
  // command and address
  input wire logic                csN,
  input wire logic                rasN,
  input wire logic                casN,
  input wire logic                weN,
  input wire logic [1:0]          bankSel,
  input wire logic [`DMRB_AW-1:0] addr,
  // data
  input wire logic [`DMRB_DW-1:0] wrData,
  input wire logic [`DMRB_DW-1:0] rdData,
  input wire logic                rdValid,
  input wire logic                rdHalf
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----
  // mode tracking
  // ----
  logic       isMode;
  logic       isRead;
  logic [2:0] lat;
  logic [2:0] next_lat;
  logic [3:0] burstLen;
  logic [3:0] next_burstLen;
  logic [3:0] runLen;
  logic [3:0] next_runLen;

  assign isMode = {csN, rasN, casN, weN} == 4'h0;
  assign isRead = {csN, rasN, casN, weN} == 4'h5;

  always_comb begin
    next_lat      = isMode ? addr[6:4] : lat;
    next_burstLen = isMode ? 4'h1 << addr[1:0] : burstLen;
    next_runLen   = rdValid ? runLen + 4'h1 : 4'h0;
  end

  // reset values follow the memory end's power-on mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lat      <= 3'h2;
      burstLen <= 4'h2;
      runLen   <= 4'h0;
    end else begin
      lat      <= next_lat;
      burstLen <= next_burstLen;
      runLen   <= next_runLen;
    end
  end

  // ----
  // properties
  // ----
  // rdValid is a register: it is seen one edge after edge n+m
  sequence first_word;
    !rdValid ##1 rdValid;
  endsequence

  mode_bank_a: assert property (isMode |-> bankSel == 2'h0)
    else $error("mode write with bank select set");
  mode_op_a: assert property (isMode |-> addr[12:7] inside {6'h00, 6'h02})
    else $error("reserved operating mode written");
  mode_len_a: assert property (isMode |-> addr[2:0] inside {3'h1, 3'h2, 3'h3})
    else $error("reserved burst length written");
  mode_lat_a: assert property (isMode |-> addr[6:4] inside {3'h2, 3'h6, 3'h3})
    else $error("reserved latency written");
  lat_two_a: assert property (isRead && lat == 3'h2 |-> ##2 first_word)
    else $error("first read word late or early at latency two");
  lat_three_a: assert property (isRead && lat != 3'h2 |-> ##3 first_word)
    else $error("first read word late or early at longer latency");
  half_flag_a: assert property (rdValid |-> rdHalf == (lat == 3'h6))
    else $error("half cycle flag wrong");
  burst_run_a: assert property ($fell(rdValid) |-> runLen == burstLen)
    else $error("read burst length wrong");
  data_cause_a: assert property ($rose(rdValid) |-> $past(isRead, 2) || $past(isRead, 3)
                                 || $past(isRead, 4))
    else $error("read data without read command");
endmodule

//--- tb/tb.sv
// self-checking bench: controller end joined to memory end
// assumes the design files compile before this one
`timescale 1ns/1ps
`include "dmrb_defs.svh"

module tb;
  typedef struct packed {
    logic [12:0] mode;
    logic [1:0]  bank;
    logic [3:0]  col;
    logic [7:0]  data;
  } dmrb_row_t;

  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        reqValid = 1'b0;
  logic [1:0]  reqOp = 2'h0;
  logic [1:0]  reqBank = 2'h0;
  logic [12:0] reqAddr = 13'h0000;
  logic [7:0]  reqData = 8'h00;
  logic        reqReady, rspValid, rspHalf, reqRefused, busy;
  logic [7:0]  rspData;
  logic [2:0]  burstLenCode, readLatencySetting;
  logic [5:0]  opMode;
  logic        burstOrder, dllResetBit, burstBusy;
  int          num_errors = 0;
  int          num_checks = 0;
  int          dllCnt = 0;
  int          refCnt = 0;
  logic        sawFull = 1'b0;
  logic        lastHalf = 1'b0;
  logic [7:0]  memModel [64];
  logic [7:0]  rq [$];
  // mode, bank, start column, first data word
  dmrb_row_t   rows [6] = '{
    '{13'h0022, 2'h0, 4'h1, 8'h10}, '{13'h003A, 2'h1, 4'h1, 8'h20},
    '{13'h0063, 2'h2, 4'h5, 8'h30}, '{13'h013B, 2'h3, 4'hE, 8'h40},
    '{13'h0029, 2'h1, 4'h7, 8'h50}, '{13'h0031, 2'h3, 4'h6, 8'h60}};

  dmrb_if link ();
  dmrb_host dmrb_host_inst (.clk, .reset, .link(link), .reqValid, .reqReady, .reqOp,
    .reqBank, .reqAddr, .reqData, .rspValid, .rspData, .rspHalf, .reqRefused, .busy);
  dmrb_device dmrb_device_inst (.clk, .reset, .link(link), .burstLenCode, .burstOrder,
    .readLatencySetting, .opMode, .dllResetBit, .burstBusy);
  dmrb_properties dmrb_properties_inst (.clk, .reset, .csN(link.csN), .rasN(link.rasN),
    .casN(link.casN), .weN(link.weN), .bankSel(link.bankSel), .addr(link.addr),
    .wrData(link.wrData), .rdData(link.rdData), .rdValid(link.rdValid), .rdHalf(link.rdHalf));

  always #12.5 clk = ~clk;

  // outputs sampled mid-cycle, well away from the launching edge
  always @(negedge clk) begin
    if (rspValid === 1'b1) begin
      rq.push_back(rspData);
      lastHalf = rspHalf;
    end
    if (dllResetBit === 1'b1) dllCnt++;
    if (reqRefused === 1'b1) refCnt++;
    if (reqValid && reqReady === 1'b0) sawFull = 1'b1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // valid stays high so back-to-back calls keep the queue full
  task automatic push(input logic [1:0] op, input logic [1:0] bk, input logic [12:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk);
    reqValid = 1'b1;
    reqOp = op;
    reqBank = bk;
    reqAddr = a;
    reqData = d;
    while (reqReady !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (reqReady !== 1'b1) num_errors++;
    @(posedge clk);
  endtask

  // busy drops for one cycle between queued commands, so wait for two quiet cycles
  task automatic settle();
    int n;
    int quiet;
    n = 0;
    quiet = 0;
    @(negedge clk);
    reqValid = 1'b0;
    while (quiet < 2 && n < 100) begin
      @(negedge clk);
      quiet = (busy === 1'b0) ? quiet + 1 : 0;
      n++;
    end
    if (quiet < 2) num_errors++;
    repeat (4) @(negedge clk);
  endtask

  task automatic chkMode(input logic [12:0] m);
    check(burstLenCode, m[2:0]);
    check(burstOrder, m[3]);
    check(readLatencySetting, m[6:4]);
    check(opMode, 6'h00);
  endtask

  function automatic logic [3:0] colAt(input logic [3:0] s, input logic [12:0] m, input int k);
    logic [3:0] mask;
    mask = (4'h1 << m[1:0]) - 4'h1;
    return (s & ~mask) | ((m[3] ? (s ^ k[3:0]) : (s + k[3:0])) & mask);
  endfunction

  task automatic rdChk(input logic [1:0] bk, input logic [3:0] s, input logic [12:0] m);
    push(2'h0, bk, {9'h000, s}, 8'h00);
    settle();
    check(rq.size(), 1 << m[1:0]);
    check(lastHalf, m[6:4] == 3'h6);
    for (int k = 0; k < (1 << m[1:0]); k++)
      check(rq.pop_front(), memModel[{bk, colAt(s, m, k)}]);
  endtask

  initial begin
    int expDll;
    expDll = 0;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    chkMode(13'h0021);
    foreach (rows[i]) begin
      push(2'h2, 2'h1, rows[i].mode, 8'h00);
      settle();
      expDll += rows[i].mode[8];
      check(dllCnt, expDll);
      check(dllResetBit, 1'b0);
      chkMode(rows[i].mode);
      push(2'h1, rows[i].bank, {9'h000, rows[i].col}, rows[i].data);
      settle();
      for (int k = 0; k < (1 << rows[i].mode[1:0]); k++)
        memModel[{rows[i].bank, colAt(rows[i].col, rows[i].mode, k)}] = rows[i].data + k;
      rdChk(rows[i].bank, colAt(rows[i].col, rows[i].mode, 1), rows[i].mode);
    end
    // reserved length, then reserved operating mode
    push(2'h2, 2'h0, 13'h0024, 8'h00);
    push(2'h2, 2'h0, 13'h0422, 8'h00);
    settle();
    check(refCnt, 2);
    chkMode(13'h0031);
    repeat (4) push(2'h2, 2'h0, 13'h0022, 8'h00);
    settle();
    check(sawFull, 1'b1);
    rdChk(2'h0, 4'h2, 13'h0022);
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    chkMode(13'h0021);
    end_sim();
  end

  initial begin
    #(25 * 4000);
    num_errors++;
    end_sim();
  end
endmodule
